/* pfc_pkg.sv */
package pfc_pkg;
    // ==========================================
    // Register map
    localparam logic [11:0] PFC_OFS_CTRL1 = 12'h024;
    localparam logic [11:0] PFC_OFS_STRAP = 12'h028;
    localparam logic [11:0] PFC_OFS_STAT = 12'h02C;
    localparam int PFC_CTRL1_INDEX = 9;
    localparam int PFC_BIT_RMII_ENH = 9;
    localparam int PFC_BIT_TDR_AUTO = 8;
    localparam int PFC_BIT_LL_RECOV = 7;
    localparam int PFC_BIT_FAST_MDIX = 6;
    localparam int PFC_BIT_ROBUST_MDIX = 5;
    localparam logic [15:0] PFC_CTRL1_WMASK = 16'h03E0;
    localparam logic [15:0] PFC_CTRL1_RESET = 16'h0000;
    localparam logic [3:0] PFC_FALSE_CARRIER_RXD = 4'h2;
    localparam logic [3:0] PFC_SYMERR_RXD = 4'h1;
    // ==========================================
    // Timing
    localparam int PFC_CLK_MHZ = 250;
    localparam int PFC_LINK_LOSS_US = 250;
    localparam int PFC_LINK_LOSS_CYC = PFC_LINK_LOSS_US * PFC_CLK_MHZ;
    localparam int PFC_RECOV_MS = 4;
    localparam int PFC_RECOV_CYC = PFC_RECOV_MS * 1000 * PFC_CLK_MHZ;

    typedef struct packed {
        logic crs_dv;
        logic rx_er;
        logic [1:0] rxd;
    } pfc_rmii_rx_t;

    typedef struct packed {
        logic active;
        logic false_carrier;
        logic sym_err;
        logic [3:0] nibble;
    } pfc_rx_event_t;
endpackage

/* pfc_ctrl1.sv */
`timescale 1ns/100ps
// Contract
// - Bit 9 picks enhanced RMII; resets normal
// - Normal mode: data-valid high when not idle
// - Normal false carrier: error, data 0010
// - Normal false carrier holds until event ends
// - Enhanced false carrier drops data-valid for event
// - Normal: start intact, error per symbol error
// - Normal: data becomes 1 from first error
// - Enhanced: data-valid drops at first error
// - Bit 8 launches diagnostic after link down
// - Bit 7 rides through brief signal loss
// - Without recovery, link down after 250 us
// - Bit 6 shortens forced-100 crossover resolution
// - Bit 5 enables robust crossover resolution
// - Bit 5 cleared disables automatic crossover
// - 100M auto-crossover strap sets bit 5
module pfc_ctrl1
    import pfc_pkg::*;
#(
    parameter int LINK_LOSS_CYC = PFC_LINK_LOSS_CYC,
    parameter int RECOV_CYC = PFC_RECOV_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Straps, sampled after reset release
    input wire logic strap_100m_i,
    input wire logic strap_amdix_i,
    // Receive event from PCS, same clock
    input wire pfc_rx_event_t rx_evt_i,
    // Signal detect from analog front end
    input wire logic sig_det_i,
    // RMII receive toward MAC
    output pfc_rmii_rx_t rmii_rx_o,
    // Link and feature controls
    output logic link_up_o,
    output logic tdr_start_o,
    output logic amdix_en_o,
    output logic amdix_fast_o,
    output logic amdix_robust_o
);
    // ==========================================
    // Register file
    logic [15:0] ctrl_q;
    logic strap_done_q;
    logic wr_en;
    logic rd_hit;

    assign wr_en = psel_i && penable_i && pwrite_i;
    assign rd_hit = (paddr_i == PFC_OFS_CTRL1) || (paddr_i == PFC_OFS_STAT);
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !rd_hit && (paddr_i != PFC_OFS_STRAP);

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ctrl_q <= PFC_CTRL1_RESET;
            strap_done_q <= 1'b0;
        end else begin
            if (wr_en && paddr_i == PFC_OFS_CTRL1) begin
                ctrl_q <= pwdata_i[15:0] & PFC_CTRL1_WMASK;
            end
            // Straps only settle after reset, so capture once afterwards
            if (!strap_done_q) begin
                strap_done_q <= 1'b1;
                if (strap_100m_i && strap_amdix_i) begin
                    ctrl_q[PFC_BIT_ROBUST_MDIX] <= 1'b1;
                end
            end
        end
    end

    logic rmii_enh;
    assign rmii_enh = ctrl_q[PFC_BIT_RMII_ENH];
    assign amdix_en_o = ctrl_q[PFC_BIT_ROBUST_MDIX];
    assign amdix_robust_o = ctrl_q[PFC_BIT_ROBUST_MDIX];
    assign amdix_fast_o = ctrl_q[PFC_BIT_FAST_MDIX] && amdix_en_o;

    // ==========================================
    // Signal detect synchroniser
    logic sig_m_q;
    logic sig_s_q;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            sig_m_q <= 1'b0;
            sig_s_q <= 1'b0;
        end else begin
            sig_m_q <= sig_det_i;
            sig_s_q <= sig_m_q;
        end
    end

    // ==========================================
    // Link monitor
    logic [31:0] loss_cnt_q;
    logic link_q;
    logic [31:0] loss_limit;

    assign loss_limit = ctrl_q[PFC_BIT_LL_RECOV] ? 32'(RECOV_CYC) : 32'(LINK_LOSS_CYC);

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            loss_cnt_q <= 32'h00000000;
            link_q <= 1'b0;
        end else if (sig_s_q) begin
            loss_cnt_q <= 32'h00000000;
            link_q <= 1'b1;
        end else if (link_q) begin
            if (loss_cnt_q >= loss_limit - 32'h00000001) begin
                link_q <= 1'b0;
                loss_cnt_q <= 32'h00000000;
            end else begin
                loss_cnt_q <= loss_cnt_q + 32'h00000001;
            end
        end
    end
    assign link_up_o = link_q;

    // Diagnostic launch pulse on the falling edge of link
    logic link_prev_q;
    logic tdr_q;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            link_prev_q <= 1'b0;
            tdr_q <= 1'b0;
        end else begin
            link_prev_q <= link_q;
            tdr_q <= link_prev_q && !link_q && ctrl_q[PFC_BIT_TDR_AUTO];
        end
    end
    assign tdr_start_o = tdr_q;

    // ==========================================
    // RMII receive shaping
    logic fc_q;
    logic se_q;
    logic nib_hi_q;
    logic fc_now;
    logic se_now;
    logic [3:0] nib;
    pfc_rmii_rx_t rx_q;

    assign fc_now = fc_q || rx_evt_i.false_carrier;
    assign se_now = se_q || rx_evt_i.sym_err;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            fc_q <= 1'b0;
            se_q <= 1'b0;
        end else if (!rx_evt_i.active) begin
            fc_q <= 1'b0;
            se_q <= 1'b0;
        end else begin
            fc_q <= fc_now;
            se_q <= se_now;
        end
    end

    // Two dibits per nibble; low dibit first
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            nib_hi_q <= 1'b0;
        end else if (!rx_evt_i.active) begin
            nib_hi_q <= 1'b0;
        end else begin
            nib_hi_q <= !nib_hi_q;
        end
    end

    always_comb begin
        nib = rx_evt_i.nibble;
        if (fc_now) begin
            nib = PFC_FALSE_CARRIER_RXD;
        end else if (se_now) begin
            nib = PFC_SYMERR_RXD;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rx_q <= '0;
        end else begin
            rx_q.rxd <= nib_hi_q ? nib[3:2] : nib[1:0];
            if (rmii_enh) begin
                // Disqualify rest of event instead of flagging errors
                rx_q.crs_dv <= rx_evt_i.active && !fc_now && !se_now;
                rx_q.rx_er <= 1'b0;
            end else begin
                rx_q.crs_dv <= rx_evt_i.active;
                rx_q.rx_er <= rx_evt_i.active && (fc_now || rx_evt_i.sym_err);
            end
        end
    end
    assign rmii_rx_o = rx_q;

    // ==========================================
    // Read data
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            prdata_o <= 32'h00000000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            unique case (paddr_i)
                PFC_OFS_CTRL1: prdata_o <= {16'h0000, ctrl_q};
                PFC_OFS_STAT: prdata_o <= {29'h00000000, tdr_q, link_q, rx_evt_i.active};
                default: prdata_o <= 32'h00000000;
            endcase
        end
    end
endmodule

/* pfc_ctrl1_chk.sv */
`timescale 1ns/100ps
module pfc_ctrl1_chk
    import pfc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire pfc_rx_event_t rx_evt_i,
    input wire pfc_rmii_rx_t rmii_rx_o,
    input wire logic link_up_o,
    input wire logic tdr_start_o,
    input wire logic amdix_en_o,
    input wire logic amdix_fast_o,
    input wire logic amdix_robust_o
);
    // ==========================================
    // Shadow of the receive mode bit
    logic enh_q;
    logic na;
    logic ea;
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            enh_q <= 1'h0;
        end else if (psel_i && penable_i && pwrite_i && paddr_i == PFC_OFS_CTRL1) begin
            enh_q <= pwdata_i[PFC_BIT_RMII_ENH];
        end
    end
    assign na = !enh_q && rx_evt_i.active;
    assign ea = enh_q && rx_evt_i.active;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    chk_dv_normal: assert property (na |=> rmii_rx_o.crs_dv)
        else $error("data valid low in normal mode");
    chk_fc_normal: assert property (na && rx_evt_i.false_carrier |=> rmii_rx_o.rx_er)
        else $error("false carrier without error");
    chk_fc_hold: assert property (na && rx_evt_i.false_carrier ##1 rx_evt_i.active |=> rmii_rx_o.rx_er)
        else $error("false carrier error not held");
    chk_fc_enh: assert property (ea && rx_evt_i.false_carrier |=> !rmii_rx_o.crs_dv)
        else $error("enhanced false carrier kept valid");
    chk_sym_normal: assert property (na && rx_evt_i.sym_err |=> rmii_rx_o.rx_er)
        else $error("symbol error not flagged");
    chk_sym_enh: assert property (ea && rx_evt_i.sym_err |=> !rmii_rx_o.crs_dv)
        else $error("enhanced symbol error kept valid");
    chk_fast_mdix: assert property (amdix_fast_o |-> amdix_robust_o)
        else $error("fast crossover without crossover");
    chk_mdix_off: assert property (amdix_en_o == amdix_robust_o)
        else $error("crossover enable mismatch");
    chk_tdr_pulse: assert property (tdr_start_o |-> $past(link_up_o, 2) && !$past(link_up_o))
        else $error("diagnostic start not after link drop");
    cover property (na && rx_evt_i.false_carrier);
    cover property (ea && rx_evt_i.sym_err);
    cover property ($fell(link_up_o));
endmodule

bind pfc_ctrl1 pfc_ctrl1_chk chk_u (.*);

/* pfc_mac_model.sv */
`timescale 1ns/100ps
module pfc_mac_model
    import pfc_pkg::*;
(
    input wire logic clk_i,
    input wire pfc_rmii_rx_t rmii_rx_i,
    output logic [3:0] nib_o
);
    // ==========================================
    // Newest dibit lands in the upper half
    always_ff @(posedge clk_i) begin
        nib_o <= {rmii_rx_i.rxd, nib_o[3:2]};
    end
endmodule

/* tb_pfc_ctrl1.sv */
`timescale 1ns/100ps
module tb_pfc_ctrl1
    import pfc_pkg::*;
;
    logic clk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
    logic strap_100m_i, strap_amdix_i, sig_det_i, link_up_o, tdr_start_o;
    logic amdix_en_o, amdix_fast_o, amdix_robust_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [3:0] nib;
    pfc_rx_event_t rx_evt_i;
    pfc_rmii_rx_t rmii_rx_o;
    int miscompares = 0;
    int cmp_count = 0;
    int tdr_n = 0;
    // ==========================================
    // Short link timers keep the run brief
    pfc_ctrl1 #(.LINK_LOSS_CYC(20), .RECOV_CYC(50)) dut_u (.*);
    pfc_mac_model mac_u (.clk_i(clk_i), .rmii_rx_i(rmii_rx_o), .nib_o(nib));
    initial begin
        clk_i = 1'h0;
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) if (tdr_start_o === 1'h1) tdr_n++;
    task cmp(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task stop_test;
        $display("cmp_count=%0d miscompares=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'h2, w, a, d};
        @(posedge clk_i);
        penable_i <= 1'h1;
        do @(posedge clk_i); while (pready_o !== 1'h1);
        rd = prdata_o;
        err = pslverr_o;
        {psel_i, penable_i} <= 2'h0;
    endtask
    // Error injected on an even cycle so it meets a low dibit
    task rx_run(input logic fc, input logic enh);
        @(posedge clk_i) rx_evt_i <= '{1'h1, 1'h0, 1'h0, 4'h5};
        repeat (2) @(posedge clk_i);
        rx_evt_i.false_carrier <= fc;
        rx_evt_i.sym_err <= !fc;
        @(posedge clk_i) rx_evt_i.sym_err <= 1'h0;
        @(negedge clk_i);
        cmp(rmii_rx_o.crs_dv, !enh);
        cmp(rmii_rx_o.rx_er, !enh);
        if (!enh) cmp(nib, 32'h5);
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        if (!enh) cmp(nib, fc ? 32'h2 : 32'h1);
        @(posedge clk_i) rx_evt_i <= '0;
    endtask
    initial begin
        {psel_i, penable_i, pwrite_i, rstn_i, paddr_i, pwdata_i} = '0;
        {strap_100m_i, strap_amdix_i, sig_det_i} = 3'h7;
        rx_evt_i = '0;
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'h1;
        apb(1'h0, PFC_OFS_CTRL1, 32'h0);
        cmp(rd, 32'h20);
        cmp(amdix_robust_o, 1'h1);
        apb(1'h1, PFC_OFS_CTRL1, 32'hFFFFFFFF);
        apb(1'h0, PFC_OFS_CTRL1, 32'h0);
        cmp(rd, 32'h3E0);
        cmp(amdix_fast_o, 1'h1);
        apb(1'h0, 12'h030, 32'h0);
        cmp(err, 1'h1);
        for (int m = 0; m < 2; m++) begin
            apb(1'h1, PFC_OFS_CTRL1, m ? 32'h200 : 32'h0);
            // Let the write settle before looking at the register outputs
            @(negedge clk_i);
            cmp(amdix_en_o, 1'h0);
            for (int k = 0; k < 2; k++) rx_run(k[0], m[0]);
        end
        apb(1'h1, PFC_OFS_CTRL1, 32'h100);
        cmp(link_up_o, 1'h1);
        @(posedge clk_i) sig_det_i <= 1'h0;
        repeat (10) @(posedge clk_i);
        cmp(link_up_o, 1'h1);
        repeat (30) @(posedge clk_i);
        cmp(link_up_o, 1'h0);
        cmp(tdr_n, 32'h1);
        sig_det_i <= 1'h1;
        apb(1'h1, PFC_OFS_CTRL1, 32'h80);
        repeat (40) @(posedge clk_i);
        sig_det_i <= 1'h0;
        repeat (30) @(posedge clk_i);
        // Without recovery the link would already be down here
        cmp(link_up_o, 1'h1);
        sig_det_i <= 1'h1;
        repeat (10) @(posedge clk_i);
        cmp(link_up_o, 1'h1);
        cmp(tdr_n, 32'h1);
        stop_test;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        miscompares++;
        stop_test;
    end
endmodule
